// *** design/flash_access_protection.sv ***
// Flash access protection checker with Wishbone control registers
// What this block does
// - Data reads go to external RAM only.
// - Writes need write enable; erase needs both.
// - Lock byte at last user byte sets security.
// - First inverse-of-lock-byte pages are locked.
// - Lock byte page locked when any bit clear.
// - Unlocked pages open to everyone.
// - Locked pages: debug refused, unlocked code resets.
// - No lock: lock page and byte open.
// - Locked: lock page refused to debug, unlocked code resets.
// - No lock: lock page erase debug only.
// - Locked: only debug device erase clears lock.
// - Lock byte changes refused or reset.
// - Reserved area access refused or reset.
// - Device erase clears every page.
// - Firmware violation resets, error flag set.
// - Debug violations dropped without reset.
// - Programmed lock byte fixed until device erase, or debug lock page erase while no lock is active.
// - New lock applies after next reset.
// - Write with erase enable erases page.
// - Two key codes enable one operation.
// - Bad key sequence disables until reset.
`timescale 1ns/100ps
`default_nettype none
module flash_access_protection import flash_prot_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter logic [ADDR_W-1:0] LOCK_ADDR = ADDR_W'(LOCK_ADDR_RST)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_req_i,
  input wire logic [1:0] cpu_op_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [ADDR_W-1:0] cpu_pc_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic dbg_req_i,
  input wire logic [1:0] dbg_op_i,
  input wire logic [ADDR_W-1:0] dbg_addr_i,
  input wire logic [7:0] dbg_wdata_i,
  output logic dbg_ack_o,
  input wire logic [7:0] lock_byte_i,
  output logic flash_stb_o,
  output logic [2:0] flash_cmd_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic xram_stb_o,
  output logic xram_we_o,
  output logic [ADDR_W-1:0] xram_addr_o,
  output logic [7:0] xram_wdata_o,
  output logic err_reset_o
);
  localparam logic [7:0] LOCK_PG = 8'(LOCK_ADDR >> PAGE_SHIFT);

  generate
    if (ADDR_W < PAGE_SHIFT + 1 || ADDR_W > 16) begin : g_bad_width
      $error("ADDR_W out of range");
    end
  endgenerate

  // Page index of an address
  function automatic logic [7:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = 8'(a >> PAGE_SHIFT);
  endfunction

  // Locked test of an address against a lock byte
  function automatic logic pg_locked(input logic [ADDR_W-1:0] a, input logic [7:0] lk);
    logic [7:0] pg;
    pg = page_of(a);
    pg_locked = (pg < ~lk) || (pg == LOCK_PG && lk != LOCK_ERASED);
  endfunction

  // Addresses above the lock byte are reserved
  function automatic logic is_resv(input logic [ADDR_W-1:0] a);
    is_resv = (a > LOCK_ADDR);
  endfunction

  logic ctrl_we_r;
  logic ctrl_ee_r;
  logic [7:0] lock_active_r;
  logic [7:0] lock_stored_r;
  logic load_r;
  logic ferr_flag_r;
  logic err_pend_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic flash_stb_r;
  logic [2:0] flash_cmd_r;
  logic [ADDR_W-1:0] flash_addr_r;
  logic [7:0] flash_wdata_r;
  logic xram_stb_r;
  logic xram_we_r;
  logic [ADDR_W-1:0] xram_addr_r;
  logic [7:0] xram_wdata_r;
  logic err_r;
  logic key_armed;
  logic key_dead;

  // Register bus decode
  wire bus_hit = wb_cyc_i && wb_stb_i && !ack_r;
  wire bus_wr = bus_hit && wb_we_i && wb_sel_i[0];
  wire ctrl_wr = bus_wr && (wb_adr_i == CTRL_OFS);
  wire key_wr = bus_wr && (wb_adr_i == KEY_OFS);
  wire lock_pend = (lock_stored_r != lock_active_r);
  wire [31:0] rd_mux =
    (wb_adr_i == CTRL_OFS) ? {30'h0, ctrl_ee_r, ctrl_we_r} :
    (wb_adr_i == STAT_OFS) ? {28'h0, lock_pend, key_armed, key_dead, ferr_flag_r} :
    (wb_adr_i == LOCK_OFS) ? {16'h0, lock_stored_r, lock_active_r} :
    32'h0;

  // Firmware request classes
  wire cpu_on = cpu_req_i && !load_r;
  wire fw_xread = cpu_on && (cpu_op_i == CPU_XREAD);
  wire fw_xw = cpu_on && (cpu_op_i == CPU_XWRITE);
  wire fw_cread = cpu_on && (cpu_op_i == CPU_CREAD);
  wire fw_fwr = fw_xw && ctrl_we_r;
  wire fw_ers = fw_fwr && ctrl_ee_r;
  wire fw_xram = fw_xread || (fw_xw && !ctrl_we_r);
  wire fw_keyfail = fw_fwr && !key_armed;
  wire fw_try = fw_cread || (fw_fwr && key_armed);
  wire any_locked = (lock_active_r != LOCK_ERASED);
  wire lb_set = (lock_stored_r != LOCK_ERASED);
  wire caller_lk = pg_locked(cpu_pc_i, lock_active_r);
  wire fw_lkpg = (page_of(cpu_addr_i) == LOCK_PG);
  wire fw_lbchg = fw_fwr && !ctrl_ee_r && (cpu_addr_i == LOCK_ADDR) && lb_set;
  wire fw_viol = is_resv(cpu_addr_i)
    || (pg_locked(cpu_addr_i, lock_active_r) && !caller_lk)
    || (fw_ers && fw_lkpg)
    || fw_lbchg;
  wire fw_bad = fw_try && fw_viol;
  wire fw_ok = fw_try && !fw_viol;

  // Debug requests, firmware has priority
  wire dbg_take = dbg_req_i && !cpu_req_i && !load_r;
  wire dbg_dev = (dbg_op_i == DBG_DEV_ERASE);
  wire dbg_ers = (dbg_op_i == DBG_PAGE_ERASE);
  wire dbg_wr = (dbg_op_i == DBG_WRITE);
  wire dbg_lkpg = (page_of(dbg_addr_i) == LOCK_PG);
  wire dbg_viol = !dbg_dev && (is_resv(dbg_addr_i)
    || pg_locked(dbg_addr_i, lock_active_r)
    || (dbg_ers && dbg_lkpg && any_locked)
    || (dbg_wr && dbg_addr_i == LOCK_ADDR && lb_set));
  wire dbg_ok = dbg_take && !dbg_viol;

  wire [2:0] fw_cmd = fw_cread ? FC_READ : (fw_ers ? FC_PAGE_ERASE : FC_WRITE);
  wire [2:0] dbg_cmd = dbg_dev ? FC_DEV_ERASE : dbg_ers ? FC_PAGE_ERASE :
    dbg_wr ? FC_WRITE : FC_READ;
  wire go_cmd_ers = fw_ok ? (fw_cmd == FC_PAGE_ERASE) : (dbg_ok && dbg_cmd != FC_READ
    && dbg_cmd != FC_WRITE);
  wire [ADDR_W-1:0] go_addr = fw_ok ? cpu_addr_i : dbg_addr_i;
  wire go_lkpg = (page_of(go_addr) == LOCK_PG);
  wire go_lbwr = (fw_ok && fw_cmd == FC_WRITE && cpu_addr_i == LOCK_ADDR)
    || (dbg_ok && dbg_wr && dbg_addr_i == LOCK_ADDR);
  wire [7:0] go_wdata = fw_ok ? cpu_wdata_i : dbg_wdata_i;
  wire dev_ers = dbg_ok && dbg_dev;

  flash_key_seq u_key (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_wr_i(key_wr),
    .key_data_i(wb_dat_i[7:0]),
    .use_i(fw_fwr),
    .armed_o(key_armed),
    .dead_o(key_dead)
  );

  // Bus slave and control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      ctrl_we_r <= CTRL_WE_RST;
      ctrl_ee_r <= CTRL_EE_RST;
    end else begin
      ack_r <= bus_hit;
      rdata_r <= bus_hit ? rd_mux : 32'h0;
      if (ctrl_wr) begin
        ctrl_we_r <= wb_dat_i[WE_BIT];
        ctrl_ee_r <= wb_dat_i[EE_BIT];
      end
    end
  end

  // Lock state: active copy only moves at reset or device erase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_r <= 1'b1;
      lock_active_r <= LOCK_ERASED;
      lock_stored_r <= LOCK_ERASED;
    end else if (load_r) begin
      load_r <= 1'b0;
      lock_active_r <= lock_byte_i;
      lock_stored_r <= lock_byte_i;
    end else if (dev_ers) begin
      lock_active_r <= LOCK_ERASED;
      lock_stored_r <= LOCK_ERASED;
    end else if (go_cmd_ers && go_lkpg) begin
      lock_stored_r <= LOCK_ERASED;
    end else if (go_lbwr) begin
      lock_stored_r <= lock_stored_r & go_wdata;
    end
  end

  // Error flag survives the reset it causes
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      ferr_flag_r <= 1'b0;
      err_pend_r <= 1'b0;
    end else if (rst_i) begin
      ferr_flag_r <= err_pend_r;
    end else if (load_r) begin
      err_pend_r <= 1'b0;
    end else if (fw_bad) begin
      err_pend_r <= 1'b1;
    end
  end

  // Request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_stb_r <= 1'b0;
      flash_cmd_r <= FC_NONE;
      flash_addr_r <= '0;
      flash_wdata_r <= 8'h00;
      xram_stb_r <= 1'b0;
      xram_we_r <= 1'b0;
      xram_addr_r <= '0;
      xram_wdata_r <= 8'h00;
      err_r <= 1'b0;
    end else begin
      flash_stb_r <= fw_ok || dbg_ok;
      flash_cmd_r <= fw_ok ? fw_cmd : (dbg_ok ? dbg_cmd : FC_NONE);
      flash_addr_r <= go_addr;
      flash_wdata_r <= go_wdata;
      xram_stb_r <= fw_xram;
      xram_we_r <= fw_xw;
      xram_addr_r <= cpu_addr_i;
      xram_wdata_r <= cpu_wdata_i;
      err_r <= fw_bad;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign dbg_ack_o = dbg_take;
  assign flash_stb_o = flash_stb_r;
  assign flash_cmd_o = flash_cmd_r;
  assign flash_addr_o = flash_addr_r;
  assign flash_wdata_o = flash_wdata_r;
  assign xram_stb_o = xram_stb_r;
  assign xram_we_o = xram_we_r;
  assign xram_addr_o = xram_addr_r;
  assign xram_wdata_o = xram_wdata_r;
  assign err_reset_o = err_r;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  xread_route_a: assert property (
    fw_xread |=> xram_stb_o && !xram_we_o && !flash_stb_o)
    else $error("external data read reached flash");

  we_gate_a: assert property (
    fw_xw && !ctrl_we_r && !dbg_req_i |=> !flash_stb_o && xram_stb_o)
    else $error("flash modified without write enable");

  erase_gate_a: assert property (
    flash_stb_o && flash_cmd_o == FC_PAGE_ERASE && !$past(dbg_take)
      |-> $past(ctrl_we_r && ctrl_ee_r))
    else $error("page erase without both enables");

  sequence locked_read_s;
    fw_cread && pg_locked(cpu_addr_i, lock_active_r) && !caller_lk;
  endsequence
  locked_err_a: assert property (
    locked_read_s |=> err_reset_o && !flash_stb_o)
    else $error("locked page read did not reset");

  dbg_quiet_a: assert property (
    dbg_take && dbg_viol |=> !err_reset_o && !flash_stb_o)
    else $error("refused debug request had an effect");

  lock_hold_a: assert property (
    !load_r && !dev_ers |=> $stable(lock_active_r))
    else $error("active lock moved without reset");

  sequence err_then_rst_s;
    err_pend_r ##1 rst_i;
  endsequence
  err_flag_a: assert property (@(posedge clk_i) disable iff (por_i)
    err_then_rst_s |=> ferr_flag_r)
    else $error("error flag missing after flash reset");

  dev_erase_a: assert property (
    dev_ers |=> flash_stb_o && flash_cmd_o == FC_DEV_ERASE
      && lock_stored_r == LOCK_ERASED && lock_active_r == LOCK_ERASED)
    else $error("device erase did not clear all");

  key_dead_a: assert property (
    key_dead && fw_xw && ctrl_we_r |=> !flash_stb_o ##1 key_dead)
    else $error("flash modified after key failure");

  resv_err_a: assert property (
    fw_cread && is_resv(cpu_addr_i) |=> err_reset_o)
    else $error("reserved read did not reset");

  key_fail_a: assert property (
    fw_keyfail |=> key_dead && !flash_stb_o)
    else $error("write without key left flash enabled");

  dbg_locked_a: assert property (
    dbg_take && !dbg_dev && pg_locked(dbg_addr_i, lock_active_r) |=> !flash_stb_o)
    else $error("debug request reached a locked page");

  lock_change_a: assert property (
    fw_fwr && key_armed && !ctrl_ee_r && cpu_addr_i == LOCK_ADDR && lb_set
      |=> err_reset_o && !flash_stb_o)
    else $error("lock byte change did not reset");

  lkpg_erase_a: assert property (
    fw_ers && key_armed && fw_lkpg |=> err_reset_o && !flash_stb_o)
    else $error("lock page erase by firmware did not reset");

  caller_ok_a: assert property (
    fw_cread && caller_lk && !is_resv(cpu_addr_i)
      |=> flash_stb_o && flash_cmd_o == FC_READ)
    else $error("read from locked caller was refused");

  lock_load_a: assert property (
    load_r |=> lock_active_r == $past(lock_byte_i) && lock_stored_r == $past(lock_byte_i))
    else $error("lock byte not taken after reset");

  por_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
    por_i |=> !ferr_flag_r && !err_pend_r)
    else $error("power-on reset left error flag set");
endmodule
`default_nettype wire

// *** design/flash_prot_pkg.sv ***
// Shared constants and types for the flash access protection block
package flash_prot_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] KEY_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] LOCK_OFS = 4'hC;
  // Field positions
  localparam int WE_BIT = 0;
  localparam int EE_BIT = 1;
  localparam int ST_FERR_BIT = 0;
  localparam int ST_DEAD_BIT = 1;
  localparam int ST_ARMED_BIT = 2;
  localparam int ST_PEND_BIT = 3;
  localparam int LK_ACT_LSB = 0;
  localparam int LK_STO_LSB = 8;
  // Reset values
  localparam logic CTRL_WE_RST = 1'b0;
  localparam logic CTRL_EE_RST = 1'b0;
  localparam logic [7:0] LOCK_ERASED = 8'hFF;
  // Unlock codes
  localparam logic [7:0] KEY_CODE1 = 8'hA5;
  localparam logic [7:0] KEY_CODE2 = 8'hF1;
  // Flash geometry
  localparam int PAGE_SHIFT = 9;
  localparam logic [15:0] LOCK_ADDR_RST = 16'h1DFF;

  typedef enum logic [1:0] {
    CPU_CREAD = 2'b00,
    CPU_XREAD = 2'b01,
    CPU_XWRITE = 2'b10,
    CPU_NOP = 2'b11
  } cpu_op_e;

  typedef enum logic [1:0] {
    DBG_READ = 2'b00,
    DBG_WRITE = 2'b01,
    DBG_PAGE_ERASE = 2'b10,
    DBG_DEV_ERASE = 2'b11
  } dbg_op_e;

  typedef enum logic [2:0] {
    FC_NONE = 3'b000,
    FC_READ = 3'b001,
    FC_WRITE = 3'b010,
    FC_PAGE_ERASE = 3'b011,
    FC_DEV_ERASE = 3'b100
  } flash_cmd_e;

  typedef enum logic [1:0] {
    KS_IDLE = 2'b00,
    KS_HALF = 2'b01,
    KS_ARMED = 2'b10,
    KS_DEAD = 2'b11
  } key_state_e;
endpackage

// *** design/flash_key_seq.sv ***
// Unlock code sequencer gating one flash write or erase
`timescale 1ns/100ps
`default_nettype none
module flash_key_seq import flash_prot_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_data_i,
  input wire logic use_i,
  output logic armed_o,
  output logic dead_o
);
  key_state_e state_r;
  key_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      KS_IDLE: begin
        if (use_i) begin
          state_nxt = KS_DEAD;
        end else if (key_wr_i) begin
          state_nxt = (key_data_i == KEY_CODE1) ? KS_HALF : KS_DEAD;
        end
      end
      KS_HALF: begin
        if (use_i) begin
          state_nxt = KS_DEAD;
        end else if (key_wr_i) begin
          state_nxt = (key_data_i == KEY_CODE2) ? KS_ARMED : KS_DEAD;
        end
      end
      KS_ARMED: begin
        if (use_i) begin
          state_nxt = KS_IDLE;
        end else if (key_wr_i) begin
          state_nxt = KS_DEAD;
        end
      end
      KS_DEAD: state_nxt = KS_DEAD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= KS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign armed_o = (state_r == KS_ARMED);
  assign dead_o = (state_r == KS_DEAD);
endmodule
`default_nettype wire

// *** sim/far_side_model.sv ***
// Behavioural CPU core and debug port model
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic clk_i,
  input wire logic dbg_ack_i,
  output logic cpu_req_o,
  output logic [1:0] cpu_op_o,
  output logic [15:0] cpu_addr_o,
  output logic [15:0] cpu_pc_o,
  output logic [7:0] cpu_wdata_o,
  output logic dbg_req_o,
  output logic [1:0] dbg_op_o,
  output logic [15:0] dbg_addr_o,
  output logic [7:0] dbg_wdata_o
);
  // Idle bus, single clock source throughout
  initial begin
    cpu_req_o = 1'b0;
    cpu_op_o = 2'h3;
    cpu_addr_o = 16'h0;
    cpu_pc_o = 16'h0;
    cpu_wdata_o = 8'h0;
    dbg_req_o = 1'b0;
    dbg_op_o = 2'h0;
    dbg_addr_o = 16'h0;
    dbg_wdata_o = 8'h0;
  end
  // One-cycle CPU access, bus scrambled after release
  task automatic cpu_acc(input logic [1:0] op, input logic [15:0] a, pc, input logic [7:0] d);
    cpu_req_o <= 1'b1;
    cpu_op_o <= op;
    cpu_addr_o <= a;
    cpu_pc_o <= pc;
    cpu_wdata_o <= d;
    @(posedge clk_i);
    cpu_req_o <= 1'b0;
    cpu_op_o <= ~op;
    cpu_addr_o <= ~a;
    cpu_pc_o <= ~pc;
    cpu_wdata_o <= ~d;
  endtask
  // Debug request held until acknowledged, or dropped after 20 clocks
  task automatic dbg_acc(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                         output logic ok);
    int n;
    dbg_req_o <= 1'b1;
    dbg_op_o <= op;
    dbg_addr_o <= a;
    dbg_wdata_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dbg_ack_i !== 1'b1 && n < 20);
    ok = dbg_ack_i;
    dbg_req_o <= 1'b0;
    dbg_addr_o <= ~a;
    dbg_wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// *** sim/flash_access_protection_tb_top.sv ***
// Self-checking bench for the flash access protection block
`timescale 1ns/100ps
`default_nettype none
module flash_access_protection_tb_top;
  import flash_prot_pkg::*;
  localparam logic [6:0] O_NO = 7'h00;
  localparam logic [6:0] O_RD = {1'b1, FC_READ, 3'h0};
  localparam logic [6:0] O_WR = {1'b1, FC_WRITE, 3'h0};
  localparam logic [6:0] O_PE = {1'b1, FC_PAGE_ERASE, 3'h0};
  localparam logic [6:0] O_DE = {1'b1, FC_DEV_ERASE, 3'h0};
  localparam logic [6:0] O_XR = 7'h04;
  localparam logic [6:0] O_XW = 7'h06;
  localparam logic [6:0] O_ER = 7'h01;
  logic clk_i = 1'b0;
  logic rst_i, por_i, cyc, stb, we, ack, cpu_req, dbg_req, dbg_ack;
  logic f_stb, x_stb, x_we, err_rst;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [7:0] lock_b, cpu_wd, dbg_wd, f_wd, x_wd;
  logic [1:0] cpu_op, dbg_op;
  logic [15:0] cpu_addr, cpu_pc, dbg_addr, f_addr, x_addr;
  logic [2:0] f_cmd;
  int error_cnt = 0;
  int num_checks = 0;
  always #25 clk_i = ~clk_i;
  flash_access_protection #(.ADDR_W(16), .LOCK_ADDR(16'h1DFF)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpu_req_i(cpu_req), .cpu_op_i(cpu_op), .cpu_addr_i(cpu_addr),
    .cpu_pc_i(cpu_pc), .cpu_wdata_i(cpu_wd), .dbg_req_i(dbg_req), .dbg_op_i(dbg_op),
    .dbg_addr_i(dbg_addr), .dbg_wdata_i(dbg_wd), .dbg_ack_o(dbg_ack), .lock_byte_i(lock_b),
    .flash_stb_o(f_stb), .flash_cmd_o(f_cmd), .flash_addr_o(f_addr), .flash_wdata_o(f_wd),
    .xram_stb_o(x_stb), .xram_we_o(x_we), .xram_addr_o(x_addr), .xram_wdata_o(x_wd),
    .err_reset_o(err_rst));
  far_side_model i_far (
    .clk_i(clk_i), .dbg_ack_i(dbg_ack), .cpu_req_o(cpu_req), .cpu_op_o(cpu_op),
    .cpu_addr_o(cpu_addr), .cpu_pc_o(cpu_pc), .cpu_wdata_o(cpu_wd), .dbg_req_o(dbg_req),
    .dbg_op_o(dbg_op), .dbg_addr_o(dbg_addr), .dbg_wdata_o(dbg_wd));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic to_chk(input logic s);
    if (s !== 1'b1) begin
      chk("handshake", {31'h0, s}, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    to_chk(ack);
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic key(input logic [31:0] ctrl);
    wb(1'b1, KEY_OFS, {24'h0, KEY_CODE1});
    wb(1'b1, KEY_OFS, {24'h0, KEY_CODE2});
    wb(1'b1, CTRL_OFS, ctrl);
  endtask
  task automatic outs(input logic [6:0] e, input string nm, input logic [15:0] a,
                      input logic [7:0] d);
    #1;
    chk(nm, {25'h0, f_stb, f_cmd, x_stb, x_stb & x_we, err_rst}, {25'h0, e});
    if (f_stb === 1'b1) begin
      chk(nm, {16'h0, f_addr}, {16'h0, a});
    end
    if (f_stb === 1'b1 && f_cmd === FC_WRITE) begin
      chk(nm, {24'h0, f_wd}, {24'h0, d});
    end
    if (x_stb === 1'b1) begin
      chk(nm, {16'h0, x_addr}, {16'h0, a});
    end
    if (x_stb === 1'b1 && x_we === 1'b1) begin
      chk(nm, {24'h0, x_wd}, {24'h0, d});
    end
    @(posedge clk_i);
  endtask
  task automatic cpu(input logic [1:0] op, input logic [15:0] a, pc, input logic [7:0] d,
                     input logic [6:0] e, input string nm);
    i_far.cpu_acc(op, a, pc, d);
    outs(e, nm, a, d);
  endtask
  task automatic dbg(input logic [1:0] op, input logic [15:0] a, input logic [6:0] e,
                     input string nm);
    logic ok;
    i_far.dbg_acc(op, a, 8'h00, ok);
    to_chk(ok);
    outs(e, nm, a, 8'h00);
  endtask
  task automatic do_reset(input logic [7:0] lb, input logic p);
    lock_b <= lb;
    rst_i <= 1'b1;
    por_i <= p;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    rst_i = 1'b1;
    por_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    wdat = 32'h0;
    lock_b = 8'hFF;
    do_reset(8'hFD, 1'b1);
    rd(4'h2, 32'h0, "unmapped");
    rd(LOCK_OFS, 32'h0000FDFD, "lock_reg");
    cpu(CPU_CREAD, 16'h0600, 16'h0800, 8'h00, O_RD, "rd_open");
    cpu(CPU_CREAD, 16'h0100, 16'h0800, 8'h00, O_ER, "rd_lk_u");
    cpu(CPU_CREAD, 16'h0100, 16'h0200, 8'h00, O_RD, "rd_lk_l");
    dbg(DBG_READ, 16'h03FF, O_NO, "dbg_edge");
    dbg(DBG_READ, 16'h0400, O_RD, "dbg_open");
    cpu(CPU_CREAD, 16'h1DFF, 16'h0800, 8'h00, O_ER, "lkb_u");
    cpu(CPU_CREAD, 16'h1DFF, 16'h0100, 8'h00, O_RD, "lkb_l");
    dbg(DBG_WRITE, 16'h1C10, O_NO, "dbg_lkpg");
    cpu(CPU_CREAD, 16'h1E00, 16'h0100, 8'h00, O_ER, "resv_cpu");
    dbg(DBG_READ, 16'h1E00, O_NO, "resv_dbg");
    cpu(CPU_XREAD, 16'h0600, 16'h0800, 8'h00, O_XR, "xread");
    cpu(CPU_XWRITE, 16'h0600, 16'h0800, 8'h5A, O_XW, "xwr_noen");
    key(32'h1);
    rd(STAT_OFS, 32'h4, "armed");
    cpu(CPU_XWRITE, 16'h0610, 16'h0800, 8'h5A, O_WR, "fl_write");
    rd(STAT_OFS, 32'h0, "key_used");
    cpu(CPU_XWRITE, 16'h0610, 16'h0800, 8'h5A, O_NO, "no_key");
    rd(STAT_OFS, 32'h2, "dead");
    cpu(CPU_XWRITE, 16'h0610, 16'h0800, 8'h5A, O_NO, "dead_wr");
    do_reset(8'hFD, 1'b0);
    rd(STAT_OFS, 32'h1, "ferr");
    rd(CTRL_OFS, 32'h0, "ctrl_rst");
    key(32'h3);
    cpu(CPU_XWRITE, 16'h0650, 16'h0800, 8'h12, O_PE, "pg_erase");
    key(32'h3);
    cpu(CPU_XWRITE, 16'h1C00, 16'h0100, 8'h00, O_ER, "lkpg_fw");
    dbg(DBG_DEV_ERASE, 16'h0000, O_DE, "dev_erase");
    rd(LOCK_OFS, 32'h0000FFFF, "lock_clr");
    dbg(DBG_READ, 16'h0100, O_RD, "post_erase");
    wb(1'b1, CTRL_OFS, 32'h2);
    cpu(CPU_XWRITE, 16'h0650, 16'h0800, 8'h00, O_XW, "ee_only");
    do_reset(8'hFF, 1'b1);
    rd(STAT_OFS, 32'h0, "por_clr");
    dbg(DBG_READ, 16'h1DFF, O_RD, "lkb_dbg");
    cpu(CPU_CREAD, 16'h1DFF, 16'h0800, 8'h00, O_RD, "lkb_fw");
    key(32'h3);
    cpu(CPU_XWRITE, 16'h1C00, 16'h0800, 8'h00, O_ER, "lkpg_er");
    do_reset(8'hFF, 1'b1);
    dbg(DBG_PAGE_ERASE, 16'h1C00, O_PE, "lkpg_dbg");
    key(32'h1);
    cpu(CPU_XWRITE, 16'h1DFF, 16'h0800, 8'hFE, O_WR, "lock_prog");
    rd(LOCK_OFS, 32'h0000FEFF, "lock_pend");
    rd(STAT_OFS, 32'h8, "pend");
    cpu(CPU_CREAD, 16'h0100, 16'h0800, 8'h00, O_RD, "old_lock");
    do_reset(8'hFE, 1'b0);
    cpu(CPU_CREAD, 16'h0100, 16'h0800, 8'h00, O_ER, "new_lock");
    cpu(CPU_CREAD, 16'h0200, 16'h0800, 8'h00, O_RD, "pg1_open");
    key(32'h1);
    cpu(CPU_XWRITE, 16'h1DFF, 16'h0100, 8'h00, O_ER, "lock_chg");
    dbg(DBG_WRITE, 16'h1DFF, O_NO, "lock_dbg");
    tally_and_finish();
  end
endmodule
`default_nettype wire
